// [common/link_ctrl_regs.vh]
// How it works
// - random registers: write controls, read returns value
// - transmit port write pushes one byte
// - receive port read pops one byte
// - mode registers processor-written, never raise interrupts
// - mode one bits 0,1 threshold irq enables
// - mode one bit 2 enables transmit address
// - mode one bit 3 end-of-receive irq enable
// - mode one bits 4-7 enable comparator pairs
// - error mode bit n gates error bit n
// - status mode bits 0,1 reset enabled
// - status mode bits 2-6 gate status two irqs
// - status mode bit 7 passes FCS to FIFO
// - fifo mode bits 1:0 receive threshold
// - fifo mode bits 3:2 transmit threshold
// - fifo mode bit 4 selects interframe fill
// - fifo mode bits 5,7 select address recognition
// - fifo mode bit 6 includes first-byte bit 1
// - match status bit n for pair n+1
// - match status kept as two-entry FIFO
// - compare address only against enabled pairs
// - transmit address register sent when enabled
// - transmit request irq at drain threshold
`ifndef LINK_CTRL_REGS_VH
`define LINK_CTRL_REGS_VH
`define ADDR_FIRST_MATCH_BASE 8'h81
`define ADDR_SECOND_MATCH_BASE 8'h82
`define ADDR_TX_ADDRESS 8'h83
`define ADDR_MODE_ONE 8'h86
`define ADDR_ERROR_MODE 8'h87
`define ADDR_RANDOM_LOW 8'h8A
`define ADDR_RANDOM_HIGH 8'h8B
`define ADDR_FIRST_MATCH_4 8'h8C
`define ADDR_SECOND_MATCH_4 8'h8D
`define ADDR_STATUS_MODE 8'h8E
`define ADDR_FIFO_MODE 8'h8F
`define ADDR_MATCH_STATUS 8'h91
`define ADDR_TX_PORT 8'hA0
`define ADDR_RX_PORT 8'hA1
`define ADDR_FIRST_MATCH_2 8'hA2
`define ADDR_SECOND_MATCH_2 8'hA3
`define ADDR_FIRST_MATCH_3 8'hA4
`define ADDR_SECOND_MATCH_3 8'hA5
`define ADDR_EXT_FIFO_CTRL 8'hA6
`define ADDR_FLAGS 8'hA7
`define RST_MODE_ONE 8'h00
`define RST_ERROR_MODE 8'h00
`define RST_STATUS_MODE 8'h03
`define RST_FIFO_MODE 8'h00
`define RST_RANDOM 16'h0000
`define RST_STATUS_TWO 8'h10
`define FIFO_RX_EXT_FIFO_T1 6'd16
`define FIFO_RX_EXT_T2 6'd24
`define FIFO_RX_EXT_T3 6'd30
`define FIFO_TX_EXT_T1 6'd6
`define FIFO_TX_EXT_T2 6'd10
`define FIFO_TX_EXT_T3 6'd14
`define BIT_TX_THR_EN 0
`define BIT_RX_THR_EN 1
`define BIT_TX_ADDR_EN 2
`define BIT_EOP_EN 3
`define BIT_FILL_FLAGS 4
`define BIT_SINGLE_BYTE 5
`define BIT_CR_COMPARE 6
`define BIT_SECOND_ONLY 7
`define BIT_FCS_XFER 7
`define BIT_EXT_FIFO 0
`endif

// [design/byte_fifo.v]
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire rst,
  input wire push,
  input wire [WIDTH-1:0] din,
  input wire pop,
  output wire [WIDTH-1:0] dout,
  output wire full,
  output wire empty,
  output wire [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_q;
  reg [AW-1:0] rp_q;
  reg [AW:0] cnt_q;
  wire do_push;
  wire do_pop;
  // push refused when full, pop when empty
  assign do_push = push && (cnt_q != DEPTH[AW:0]);
  assign do_pop = pop && (cnt_q != {(AW+1){1'b0}});
  assign dout = mem[rp_q];
  assign full = (cnt_q == DEPTH[AW:0]);
  assign empty = (cnt_q == {(AW+1){1'b0}});
  assign count = cnt_q;
  always @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= din;
    end
  end
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= {AW{1'b0}};
      rp_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// [design/link_controller.v]
`include "link_ctrl_regs.vh"
module link_controller #(
  parameter TX_DEPTH = 16,
  parameter RX_DEPTH = 32
) (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  output reg [7:0] rdata,
  // transmit side: framer pulls bytes
  input wire tx_pull,
  output reg [7:0] tx_byte,
  output reg tx_byte_valid,
  output reg [7:0] tx_address,
  output reg tx_address_en,
  output reg fill_flags,
  // receive side: framer pushes bytes
  input wire rx_push,
  input wire [7:0] rx_data,
  input wire rx_is_fcs,
  input wire rx_addr_byte1,
  input wire rx_addr_byte2,
  input wire rx_packet_end,
  input wire rx_packet_lost,
  input wire tx_last_byte,
  input wire tx_end_packet,
  input wire [7:0] error_flags,
  input wire idle_mode,
  output reg irq
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg [7:0] mode_one_q;
  reg [7:0] error_mode_q;
  reg [7:0] status_mode_q;
  reg [7:0] fifo_mode_q;
  reg [7:0] ext_fifo_q;
  reg [15:0] random_ctrl_q;
  reg [15:0] lfsr_q;
  reg [7:0] first_match_q [0:3];
  reg [7:0] second_match_q [0:3];
  reg [7:0] tx_addr_q;
  reg [3:0] match_fifo_q [0:1];
  reg [1:0] match_cnt_q;
  reg [3:0] first_hit_q;
  reg [3:0] pending_hit_q;
  reg eorp_q;
  reg valid_address_flag_q;
  reg end_tx_q;
  reg last_rx_q;
  reg lost_q;
  reg last_tx_q;
  reg tx_req_q;
  reg rx_req_q;
  reg [7:0] error_q;
  reg rx_took_last_q;
  wire tx_full;
  wire tx_empty;
  wire [4:0] tx_count;
  wire [7:0] tx_out;
  wire rx_full;
  wire rx_empty;
  wire [5:0] rx_count;
  wire [7:0] rx_out;
  wire rx_accept;
  wire rx_pop;
  wire tx_push;
  wire [7:0] status_one;
  wire [7:0] status_two;
  reg [5:0] rx_thr;
  reg [5:0] tx_thr;
  reg [3:0] hit1;
  reg [3:0] hit2;
  integer i;
  // ---------------------------------------------------------------
  // byte FIFOs
  // ---------------------------------------------------------------
  assign tx_push = wr && (addr == `ADDR_TX_PORT);
  assign rx_pop = rd && (addr == `ADDR_RX_PORT);
  // fcs bytes are dropped unless software asked for them
  assign rx_accept = rx_push && (!rx_is_fcs || status_mode_q[`BIT_FCS_XFER]);
  byte_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH), .AW(4)) tx_fifo (
    .clk(clk),
    .rst(rst),
    .push(tx_push),
    .din(wdata),
    .pop(tx_pull),
    .dout(tx_out),
    .full(tx_full),
    .empty(tx_empty),
    .count(tx_count)
  );
  byte_fifo #(.WIDTH(8), .DEPTH(RX_DEPTH), .AW(5)) rx_fifo (
    .clk(clk),
    .rst(rst),
    .push(rx_accept),
    .din(rx_data),
    .pop(rx_pop),
    .dout(rx_out),
    .full(rx_full),
    .empty(rx_empty),
    .count(rx_count)
  );
  // ---------------------------------------------------------------
  // thresholds
  // ---------------------------------------------------------------
  // fields are only sampled live; software must hold them while idle
  always @* begin
    case (fifo_mode_q[1:0])
      2'b00: rx_thr = 6'd1;
      2'b01: rx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_RX_EXT_FIFO_T1 : 6'd2;
      2'b10: rx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_RX_EXT_T2 : 6'd4;
      2'b11: rx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_RX_EXT_T3 : 6'd8;
      default: rx_thr = 6'd1;
    endcase
    // extended 14-byte row taken on control bit 0 like its siblings
    case (fifo_mode_q[3:2])
      2'b00: tx_thr = 6'd1;
      2'b01: tx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_TX_EXT_T1 : 6'd2;
      2'b10: tx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_TX_EXT_T2 : 6'd4;
      2'b11: tx_thr = ext_fifo_q[`BIT_EXT_FIFO] ? `FIFO_TX_EXT_T3 : 6'd8;
      default: tx_thr = 6'd1;
    endcase
  end
  // ---------------------------------------------------------------
  // address comparators
  // ---------------------------------------------------------------
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      // bit 1 is the command/response bit, masked by default
      hit1[i] = mode_one_q[4+i] &&
        (((rx_data ^ first_match_q[i]) &
        {6'h3F, fifo_mode_q[`BIT_CR_COMPARE], 1'b1}) == 8'h00);
      hit2[i] = mode_one_q[4+i] && (rx_data == second_match_q[i]);
    end
  end
  // ---------------------------------------------------------------
  // sequential state
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_one_q <= `RST_MODE_ONE;
      error_mode_q <= `RST_ERROR_MODE;
      status_mode_q <= `RST_STATUS_MODE;
      fifo_mode_q <= `RST_FIFO_MODE;
      ext_fifo_q <= 8'h00;
      random_ctrl_q <= `RST_RANDOM;
      lfsr_q <= 16'h0001;
      tx_addr_q <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        first_match_q[i] <= 8'h00;
        second_match_q[i] <= 8'h00;
      end
      match_fifo_q[0] <= 4'h0;
      match_fifo_q[1] <= 4'h0;
      match_cnt_q <= 2'd0;
      first_hit_q <= 4'h0;
      pending_hit_q <= 4'h0;
      eorp_q <= 1'b0;
      valid_address_flag_q <= 1'b0;
      end_tx_q <= 1'b0;
      last_rx_q <= 1'b0;
      lost_q <= 1'b0;
      last_tx_q <= 1'b0;
      tx_req_q <= 1'b0;
      rx_req_q <= 1'b0;
      error_q <= 8'h00;
      rx_took_last_q <= 1'b0;
    end else begin
      // mode registers only change on a processor write
      if (wr) begin
        case (addr)
          `ADDR_MODE_ONE: mode_one_q <= wdata;
          `ADDR_ERROR_MODE: error_mode_q <= wdata;
          `ADDR_STATUS_MODE: status_mode_q <= wdata;
          `ADDR_FIFO_MODE: fifo_mode_q <= wdata;
          `ADDR_EXT_FIFO_CTRL: ext_fifo_q <= wdata;
          `ADDR_RANDOM_LOW: random_ctrl_q[7:0] <= wdata;
          `ADDR_RANDOM_HIGH: random_ctrl_q[15:8] <= wdata;
          `ADDR_TX_ADDRESS: tx_addr_q <= wdata;
          `ADDR_FIRST_MATCH_BASE: first_match_q[0] <= wdata;
          `ADDR_SECOND_MATCH_BASE: second_match_q[0] <= wdata;
          `ADDR_FIRST_MATCH_2: first_match_q[1] <= wdata;
          `ADDR_SECOND_MATCH_2: second_match_q[1] <= wdata;
          `ADDR_FIRST_MATCH_3: first_match_q[2] <= wdata;
          `ADDR_SECOND_MATCH_3: second_match_q[2] <= wdata;
          `ADDR_FIRST_MATCH_4: first_match_q[3] <= wdata;
          `ADDR_SECOND_MATCH_4: second_match_q[3] <= wdata;
          default: ;
        endcase
      end
      // a control write reseeds, free-running otherwise
      if (wr && (addr == `ADDR_RANDOM_LOW || addr == `ADDR_RANDOM_HIGH)) begin
        lfsr_q <= (random_ctrl_q == 16'h0000) ? 16'h0001 : random_ctrl_q;
      end else begin
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
      // address recognition, per mode
      if (rx_push && rx_addr_byte1) begin
        first_hit_q <= hit1;
      end
      if (rx_push && rx_addr_byte2) begin
        if (!fifo_mode_q[`BIT_SINGLE_BYTE]) begin
          pending_hit_q <= first_hit_q & hit2;
        end else if (fifo_mode_q[`BIT_SECOND_ONLY]) begin
          pending_hit_q <= hit2;
        end else begin
          pending_hit_q <= first_hit_q;
        end
        if (mode_one_q[7:4] == 4'h0) begin
          valid_address_flag_q <= 1'b1;
        end else if ((!fifo_mode_q[`BIT_SINGLE_BYTE] && (first_hit_q & hit2) != 4'h0) ||
            (fifo_mode_q[`BIT_SINGLE_BYTE] && fifo_mode_q[`BIT_SECOND_ONLY] && hit2 != 4'h0) ||
            (fifo_mode_q[`BIT_SINGLE_BYTE] && !fifo_mode_q[`BIT_SECOND_ONLY] &&
            first_hit_q != 4'h0)) begin
          valid_address_flag_q <= 1'b1;
        end
      end else if (rd && addr == `ADDR_FLAGS) begin
        valid_address_flag_q <= 1'b0;
      end
      // two-entry result queue; a read drops the head
      if (rd && addr == `ADDR_MATCH_STATUS && match_cnt_q != 2'd0) begin
        match_fifo_q[0] <= match_fifo_q[1];
        if (!(rx_packet_end && match_cnt_q != 2'd2)) begin
          match_cnt_q <= match_cnt_q - 2'd1;
        end
      end else if (rx_packet_end && match_cnt_q != 2'd2) begin
        match_cnt_q <= match_cnt_q + 2'd1;
      end
      // push placed after the shift so a same-cycle pop cannot overwrite it
      if (rx_packet_end && match_cnt_q != 2'd2) begin
        match_fifo_q[(rd && addr == `ADDR_MATCH_STATUS && match_cnt_q != 2'd0) ?
          match_cnt_q[0] - 1'b1 : match_cnt_q[0]] <= pending_hit_q;
      end
      // sticky flags: hardware set wins over read clear
      eorp_q <= rx_packet_end | (eorp_q & !(rd && addr == `ADDR_FLAGS));
      end_tx_q <= tx_end_packet | (end_tx_q & !(rd && addr == `ADDR_FLAGS));
      lost_q <= rx_packet_lost | (lost_q & !(rd && addr == `ADDR_FLAGS));
      last_tx_q <= tx_last_byte | (last_tx_q & !(rd && addr == `ADDR_FLAGS));
      rx_took_last_q <= rx_packet_end ? 1'b1 :
        (rx_pop && rx_count == 6'd1) ? 1'b0 : rx_took_last_q;
      last_rx_q <= (rx_pop && rx_count == 6'd1 && rx_took_last_q) |
        (last_rx_q & !(rd && addr == `ADDR_FLAGS));
      error_q <= error_flags | (error_q & ~({8{rd && addr == `ADDR_FLAGS}}));
      tx_req_q <= ({1'b0, tx_count} <= tx_thr);
      rx_req_q <= (rx_count >= rx_thr);
      if (idle_mode) begin
        eorp_q <= 1'b0;
        end_tx_q <= 1'b0;
        lost_q <= 1'b0;
        last_tx_q <= 1'b0;
        last_rx_q <= 1'b0;
        valid_address_flag_q <= 1'b0;
      end
    end
  end
  assign status_one = {1'b0, end_tx_q, 4'h0, eorp_q, valid_address_flag_q};
  assign status_two = {3'b000, !tx_full, last_tx_q, lost_q, !rx_empty, last_rx_q};
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
      irq <= 1'b0;
      tx_byte <= 8'h00;
      tx_byte_valid <= 1'b0;
      tx_address <= 8'h00;
      tx_address_en <= 1'b0;
      fill_flags <= 1'b0;
    end else begin
      tx_byte <= tx_out;
      tx_byte_valid <= !tx_empty;
      tx_address <= tx_addr_q;
      tx_address_en <= mode_one_q[`BIT_TX_ADDR_EN];
      fill_flags <= fifo_mode_q[`BIT_FILL_FLAGS];
      irq <= (mode_one_q[`BIT_TX_THR_EN] && tx_req_q) ||
        (mode_one_q[`BIT_RX_THR_EN] && rx_req_q) ||
        (mode_one_q[`BIT_EOP_EN] && (eorp_q || !rx_empty)) ||
        ((error_q & error_mode_q) != 8'h00) ||
        (status_mode_q[0] && valid_address_flag_q) ||
        (status_mode_q[1] && end_tx_q) ||
        (status_mode_q[2] && last_rx_q) ||
        (status_mode_q[3] && !rx_empty) ||
        (status_mode_q[4] && last_tx_q) ||
        (status_mode_q[5] && !tx_full) ||
        (status_mode_q[6] && lost_q);
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          `ADDR_MODE_ONE: rdata <= mode_one_q;
          `ADDR_ERROR_MODE: rdata <= error_mode_q;
          `ADDR_STATUS_MODE: rdata <= status_mode_q;
          `ADDR_FIFO_MODE: rdata <= fifo_mode_q;
          `ADDR_EXT_FIFO_CTRL: rdata <= ext_fifo_q;
          `ADDR_RANDOM_LOW: rdata <= lfsr_q[7:0];
          `ADDR_RANDOM_HIGH: rdata <= lfsr_q[15:8];
          `ADDR_TX_ADDRESS: rdata <= tx_addr_q;
          `ADDR_FIRST_MATCH_BASE: rdata <= first_match_q[0];
          `ADDR_SECOND_MATCH_BASE: rdata <= second_match_q[0];
          `ADDR_FIRST_MATCH_2: rdata <= first_match_q[1];
          `ADDR_SECOND_MATCH_2: rdata <= second_match_q[1];
          `ADDR_FIRST_MATCH_3: rdata <= first_match_q[2];
          `ADDR_SECOND_MATCH_3: rdata <= second_match_q[2];
          `ADDR_FIRST_MATCH_4: rdata <= first_match_q[3];
          `ADDR_SECOND_MATCH_4: rdata <= second_match_q[3];
          `ADDR_MATCH_STATUS: rdata <= {4'h0, match_fifo_q[0]};
          `ADDR_RX_PORT: rdata <= rx_out;
          `ADDR_FLAGS: rdata <= status_one | status_two | error_q;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// [verif/link_controller_properties.sv]
module link_controller_properties (
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire tx_byte_valid,
  input wire [7:0] tx_address,
  input wire tx_address_en,
  input wire fill_flags,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // register port
  // ----------------------------------------
  a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_reserved_bits_zero: assert property (rd && addr == 8'h91 |=> rdata[7:4] == 4'h0)
    else $error("match status upper bits not zero");
  a_mode_one_readback: assert property (wr && addr == 8'h86 ##1 rd && addr == 8'h86
    |=> rdata == $past(wdata, 2)) else $error("mode one readback mismatch");
  a_error_mode_readback: assert property (wr && addr == 8'h87 ##1 rd && addr == 8'h87
    |=> rdata == $past(wdata, 2)) else $error("error mode readback mismatch");

  // ----------------------------------------
  // outputs driven by register and port writes, and by reset
  // ----------------------------------------
  a_fill_follows_mode: assert property (wr && addr == 8'h8F |-> ##2
    fill_flags == $past(wdata[4], 2)) else $error("fill select does not follow mode");
  a_txaddr_en_follows: assert property (wr && addr == 8'h86 |-> ##2
    tx_address_en == $past(wdata[2], 2)) else $error("transmit address enable not following");
  a_txaddr_value: assert property (wr && addr == 8'h83 |-> ##2
    tx_address == $past(wdata, 2)) else $error("transmit address not updated");
  a_tx_push_valid: assert property (wr && addr == 8'hA0 |-> ##[1:2] tx_byte_valid)
    else $error("pushed byte not visible");
  a_reset_quiet: assert property ($fell(rst) |-> !irq && !tx_byte_valid && !fill_flags && !tx_address_en)
    else $error("outputs not quiet after reset");

  c_fifo_mode_write: cover property (wr && addr == 8'h8F);
  c_match_seen: cover property (rd && addr == 8'h91 ##1 rdata[0]);
  c_irq_raised: cover property ($rose(irq));
endmodule

bind link_controller link_controller_properties u_props (
  .clk(clk),
  .rst(rst),
  .addr(addr),
  .wdata(wdata),
  .wr(wr),
  .rd(rd),
  .rdata(rdata),
  .tx_byte_valid(tx_byte_valid),
  .tx_address(tx_address),
  .tx_address_en(tx_address_en),
  .fill_flags(fill_flags),
  .irq(irq)
);

// [verif/link_controller_test.sv]
module link_controller_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, wr, rd, tx_pull, rx_push, rx_is_fcs, rx_addr_byte1, rx_addr_byte2;
  logic rx_packet_end, rx_packet_lost, tx_last_byte, tx_end_packet, idle_mode;
  logic [7:0] addr, wdata, rx_data, error_flags, d, a1, a2;
  wire [7:0] rdata, tx_byte, tx_address;
  wire tx_byte_valid, tx_address_en, fill_flags, irq;
  int n_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int i, j, n;
  logic [7:0] q[$];
  logic [7:0] ra[6] = '{8'h86, 8'h87, 8'h8E, 8'h8F, 8'h91, 8'hFF};
  logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};

  link_controller dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_pull(tx_pull), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_address(tx_address), .tx_address_en(tx_address_en), .fill_flags(fill_flags),
    .rx_push(rx_push), .rx_data(rx_data), .rx_is_fcs(rx_is_fcs),
    .rx_addr_byte1(rx_addr_byte1), .rx_addr_byte2(rx_addr_byte2),
    .rx_packet_end(rx_packet_end), .rx_packet_lost(rx_packet_lost),
    .tx_last_byte(tx_last_byte), .tx_end_packet(tx_end_packet), .error_flags(error_flags),
    .idle_mode(idle_mode), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // a hang would otherwise never reach the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] v);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, 1'b0, a, v);
    bus(1'b0, 1'b0, a, v);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, 1'b1, a, 8'h00);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
    @(posedge clk);
  endtask

  task automatic rx_in(input logic [7:0] v, input logic fcs, b1, b2, eop);
    rx_push <= ~eop;
    rx_data <= v;
    rx_is_fcs <= fcs;
    rx_addr_byte1 <= b1;
    rx_addr_byte2 <= b2;
    rx_packet_end <= eop;
    @(posedge clk);
    rx_push <= 1'b0;
    rx_is_fcs <= 1'b0;
    rx_addr_byte1 <= 1'b0;
    rx_addr_byte2 <= 1'b0;
    rx_packet_end <= 1'b0;
    @(posedge clk);
  endtask

  task automatic packet(input logic [7:0] b1v, input logic [7:0] b2v);
    rx_in(b1v, 1'b0, 1'b1, 1'b0, 1'b0);
    rx_in(b2v, 1'b0, 1'b0, 1'b1, 1'b0);
    rx_in(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
  endtask

  task automatic pulse_err(input logic [7:0] e);
    error_flags <= e;
    @(posedge clk);
    error_flags <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, wr, rd, tx_pull, rx_push, rx_is_fcs, rx_addr_byte1, rx_addr_byte2} = 8'hFF;
    {wr, rd, tx_pull, rx_push, rx_is_fcs, rx_addr_byte1, rx_addr_byte2} = 7'h00;
    {rx_packet_end, rx_packet_lost, tx_last_byte, tx_end_packet, idle_mode} = 5'h00;
    {addr, wdata, rx_data, error_flags} = 32'h00000000;
    n = $urandom(32'h09052B38);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 6; i++) rchk(ra[i], rv[i]);
    idle_mode <= 1'b1;
    for (i = 0; i < 24; i++) begin
      j = i % 4;
      d = $urandom;
      bus(1'b1, 1'b0, ra[j], d);
      rchk(ra[j], d);
      if (j == 0) check(tx_address_en, d[2]);
      if (j == 3) check(fill_flags, d[4]);
    end
    d = $urandom;
    wreg(8'h83, d);
    @(negedge clk);
    check(tx_address, d);
    @(posedge clk);
    idle_mode <= 1'b0;
    for (i = 0; i < 17; i++) begin
      d = $urandom;
      if (i < 16) q.push_back(d);
      bus(1'b1, 1'b0, 8'hA0, d);
    end
    bus(1'b0, 1'b0, 8'hA0, 8'h00);
    repeat (2) @(posedge clk);
    n = 0;
    while (tx_byte_valid === 1'b1 && n < 20) begin
      if (n < 16) check(tx_byte, q[n]);
      tx_pull <= 1'b1;
      @(posedge clk);
      tx_pull <= 1'b0;
      repeat (2) @(posedge clk);
      n++;
    end
    check(n[7:0], 8'h10);
    wreg(8'h8E, 8'h00);
    d = $urandom;
    rx_in(~d, 1'b1, 1'b0, 1'b0, 1'b0);
    rx_in(d, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(8'hA1, d);
    wreg(8'h8E, 8'h80);
    rx_in(~d, 1'b1, 1'b0, 1'b0, 1'b0);
    rchk(8'hA1, ~d);
    for (i = 0; i < 3; i++) wreg(ra[i], 8'h00);
    rchk(8'hA7, 8'h10);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    wreg(8'h87, 8'hFF);
    repeat (3) @(posedge clk);
    check(irq, 1'b0);
    for (i = 0; i < 8; i++) begin
      wreg(8'h87, 8'h01 << i);
      pulse_err(8'h01 << ((i + 1) % 8));
      check(irq, 1'b0);
      pulse_err(8'h01 << i);
      check(irq, 1'b1);
      bus(1'b0, 1'b1, 8'hA7, 8'h00);
      bus(1'b0, 1'b0, 8'hA7, 8'h00);
      repeat (3) @(posedge clk);
      check(irq, 1'b0);
    end
    wreg(8'h87, 8'h00);
    wreg(8'h86, 8'h01);
    repeat (3) @(posedge clk);
    check(irq, 1'b1);
    a1 = $urandom;
    a2 = $urandom;
    wreg(8'h81, a1);
    wreg(8'h82, a2);
    wreg(8'h86, 8'h10);
    idle_mode <= 1'b1;
    wreg(8'h8F, 8'h00);
    idle_mode <= 1'b0;
    packet(a1 ^ 8'h02, a2);
    packet(a1, a2 ^ 8'h01);
    rchk(8'h91, 8'h01);
    rchk(8'h91, 8'h00);
    wreg(8'h8F, 8'h40);
    packet(a1 ^ 8'h02, a2);
    packet(a1, a2);
    rchk(8'h91, 8'h00);
    rchk(8'h91, 8'h01);
    wreg(8'h86, 8'h00);
    packet(a1, a2);
    rchk(8'h91, 8'h00);
    finish_test();
  end
endmodule
